// >>> src/trace_clock_and_tag_counter.sv
// What this block does
// - Slow class permits state counting or time counting.
// - Fast class permits state counting but refuses time mode.
// - Very fast class forces the counter to none.
// - Shallow variant takes five master clocks; deep variant only three.
// - In the deep variant the three emulator clock edge selections are fixed at reset.
// - Any one enabled master edge clocks a state.
// - Enabled level qualifiers are ORed together.
// - Time mode measures time between stored states.
// - Expression, any and none count modes exist.
// - Deep variant counts only after arm when gated; shallow refuses arm gating.
// - Arm starts false, latches on first rising trigger, stays true until an arm control write sets the clear bit.
// - Arm source selects trigger line one or two.
// - Reset and init select time mode.
// - Each stored state carries the tag value; the counter then clears.
// - Depth is 1024 states without counting, 512 with counting.
// - Simple arrangement uses a global restart; full uses per-term secondaries.
// - A term's secondary only counts while the sequencer sits there.
// - Up to eight pattern comparators build qualifier expressions.
// - Speed classes: slow up to 16 MHz, fast to 20, very fast above.
// - Low qualifier passes edges while its clock is low; high while high.
// - Primary wins when both branches hit together.
// - Secondary before primary count clears the occurrence counter.
//
// Purpose: Master clock qualification, tag counter, arm latch, secondary qualifiers
// Assumes: Bus pins are asynchronous and synchronised here; one system clock
// Notes:   Master clock index 0..4 is J,K,L,M,N
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "trace_clock_cfg.svh"

module trace_clock_and_tag_counter #(
	parameter int DEEP_VARIANT = 0,
	parameter int TAG_WIDTH    = 16,
	parameter int TERMS        = 8,
	parameter int PATTERNS     = 8
) (
	input  wire logic                         sys_clk_in,
	input  wire logic                         sys_rst_in,
	input  wire logic [4:0]                   master_clk_in,
	input  wire logic                         background_in,
	input  wire trace_clock_pkg::bus_state_t  bus_state_in,
	input  wire logic                         trigger_line_one_in,
	input  wire logic                         trigger_line_two_in,
	input  wire logic [2:0]                   seq_term_in,
	input  wire logic                         primary_hit_in,
	input  wire logic                         primary_done_in,
	input  wire logic [7:0]                   reg_addr_in,
	input  wire logic [31:0]                  reg_wdata_in,
	input  wire logic                         reg_write_in,
	input  wire logic                         reg_read_in,
	output logic [31:0]                       reg_rdata_out,
	output trace_clock_pkg::trace_word_t      trace_word_out,
	output logic                              secondary_hit_out,
	output logic                              primary_clear_out,
	output logic [10:0]                       trace_depth_out
);

	if (TAG_WIDTH < 1 || TAG_WIDTH > 16 || TERMS != 8 ||
			PATTERNS < 1 || PATTERNS > 8) begin : g_check
		$error("Unsupported parameters");
	end

	localparam logic [4:0] EMU_CLOCKS = 5'h1c;
	localparam int TB_CYC = `TIMEBASE_CYCLES;

	function automatic logic pattern_match(input trace_clock_pkg::pattern_t p,
			input logic [31:0] a);
		pattern_match = ((a & p.addr_mask) == (p.addr_value & p.addr_mask));
	endfunction

	logic [4:0]  clk_s1_q, clk_s2_q, clk_s3_q;
	logic        bg_s1_q, bg_s2_q, t1_s1_q, t1_s2_q, t2_s1_q, t2_s2_q;
	trace_clock_pkg::bus_state_t bus_s1_q, bus_s2_q;
	logic [31:0] clock_ctrl_q;
	trace_clock_pkg::count_mode_t mode_q;
	logic        arm_gate_q, arm_src_q, arm_q, trig_prev_q, complex_q;
	logic [PATTERNS-1:0] expr_sel_q;
	trace_clock_pkg::pattern_t pattern_q [PATTERNS];
	logic [PATTERNS-1:0] secondary_q [TERMS];
	logic [TAG_WIDTH-1:0] tag_q;
	logic [3:0]  tb_cnt_q;
	trace_clock_pkg::speed_class_t speed;
	logic [4:0]  lanes, rise_en, fall_en, low_en, high_en;
	logic        edge_hit, qual_ok, store, tb_tick, trig_sel;
	logic [PATTERNS-1:0] hits;
	logic        counting, count_event, armed_ok;
	logic [31:0] rdata_d;

	// Pin inputs pass two flops; third stage only for edge history
	always_ff @(posedge sys_clk_in) begin
		clk_s1_q <= master_clk_in;
		clk_s2_q <= clk_s1_q;
		clk_s3_q <= clk_s2_q;
		bg_s1_q  <= background_in;
		bg_s2_q  <= bg_s1_q;
		t1_s1_q  <= trigger_line_one_in;
		t1_s2_q  <= t1_s1_q;
		t2_s1_q  <= trigger_line_two_in;
		t2_s2_q  <= t2_s1_q;
		bus_s1_q <= bus_state_in;
		bus_s2_q <= bus_s1_q;
	end

	assign lanes   = DEEP_VARIANT != 0 ? EMU_CLOCKS : 5'h1f;
	assign rise_en = clock_ctrl_q[`CLK_EDGE_RISE_LSB +: 5] & lanes;
	assign fall_en = clock_ctrl_q[`CLK_EDGE_FALL_LSB +: 5] & lanes;
	assign low_en  = clock_ctrl_q[`CLK_QUAL_LOW_LSB +: 5] & lanes;
	assign high_en = clock_ctrl_q[`CLK_QUAL_HIGH_LSB +: 5] & lanes;
	assign speed   = trace_clock_pkg::speed_class_t'(clock_ctrl_q[`CLK_SPEED_LSB +: 3]);

	// Any enabled edge clocks a state
	assign edge_hit = |((clk_s2_q & ~clk_s3_q & rise_en) | (~clk_s2_q & clk_s3_q & fall_en));
	// Level qualifiers ORed with user and background qualifiers
	assign qual_ok = |(~clk_s2_q & low_en) | |(clk_s2_q & high_en)
		| (clock_ctrl_q[`CLK_USER_BIT] & ~bg_s2_q)
		| (clock_ctrl_q[`CLK_BACKGROUND_BIT] & bg_s2_q);
	assign store = edge_hit & qual_ok;

	// Patterns and expression select
	always_comb begin
		for (int i = 0; i < PATTERNS; i++)
			hits[i] = pattern_match(pattern_q[i], bus_s2_q.addr);
	end

	// Simple arrangement uses term 0 entry as a global restart
	assign secondary_hit_out = complex_q ? |(secondary_q[seq_term_in] & hits)
		: |(secondary_q[0] & hits);
	// Clear occurrence only when secondary taken and primary not
	assign primary_clear_out = store & secondary_hit_out & ~primary_hit_in
		& ~primary_done_in;

	assign trig_sel = arm_src_q ? t2_s2_q : t1_s2_q;
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			arm_q       <= 1'b0;
			trig_prev_q <= 1'b1;
		end else begin
			trig_prev_q <= trig_sel;
			if (reg_write_in && reg_addr_in == `REG_ARM_CTRL && reg_wdata_in[`ARM_CLEAR_BIT])
				arm_q <= 1'b0;
			else if (trig_sel && !trig_prev_q)
				arm_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			tb_cnt_q <= 4'h0;
		else if (tb_tick)
			tb_cnt_q <= 4'h0;
		else
			tb_cnt_q <= tb_cnt_q + 4'h1;
	end
	assign tb_tick = (tb_cnt_q == 4'(TB_CYC - 1));

	assign armed_ok = !arm_gate_q || arm_q;
	always_comb begin
		count_event = 1'b0;
		unique case (mode_q)
			trace_clock_pkg::count_time: count_event = tb_tick;
			trace_clock_pkg::count_expr: count_event = store & |(hits & expr_sel_q);
			trace_clock_pkg::count_any:  count_event = store;
			trace_clock_pkg::count_none: count_event = 1'b0;
			default:                     count_event = 1'b0;
		endcase
	end
	assign counting = mode_q != trace_clock_pkg::count_none;

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			tag_q <= '0;
		else if (store)
			tag_q <= '0;
		else if (count_event && armed_ok && tag_q != '1)
			tag_q <= tag_q + 1'b1;
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			trace_word_out <= '0;
		end else begin
			trace_word_out.valid     <= store;
			trace_word_out.tag_valid <= store & counting;
			if (store) begin
				trace_word_out.state <= bus_s2_q;
				trace_word_out.tag   <= 16'(tag_q);
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			trace_depth_out <= 11'(`DEPTH_WITH_COUNT);
		else
			trace_depth_out <= counting ? 11'(`DEPTH_WITH_COUNT) : 11'(`DEPTH_NO_COUNT);
	end

	// Clock control; deep variant keeps emulator edges at reset values
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			clock_ctrl_q <= `CLOCK_CTRL_RESET;
			clock_ctrl_q[`CLK_SPEED_LSB +: 3] <= speed_class_slow_code();
		end else if (reg_write_in && reg_addr_in == `REG_CLOCK_CTRL) begin
			clock_ctrl_q <= reg_wdata_in;
			if (DEEP_VARIANT != 0) begin
				clock_ctrl_q[`CLK_EDGE_RISE_LSB +: 5] <= 5'(`CLOCK_CTRL_RESET >> `CLK_EDGE_RISE_LSB);
				clock_ctrl_q[`CLK_EDGE_FALL_LSB +: 5] <= 5'(`CLOCK_CTRL_RESET >> `CLK_EDGE_FALL_LSB);
			end
			if (!(reg_wdata_in[`CLK_SPEED_LSB +: 3] inside {3'h1, 3'h2, 3'h4}))
				clock_ctrl_q[`CLK_SPEED_LSB +: 3] <= 3'h1;
		end
	end

	function automatic logic [2:0] speed_class_slow_code();
		speed_class_slow_code = 3'h1;
	endfunction

	// Count mode legality depends on speed class
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			mode_q     <= trace_clock_pkg::count_time;
			arm_gate_q <= 1'b0;
			expr_sel_q <= '0;
		end else if (speed == trace_clock_pkg::speed_class_very_fast) begin
			mode_q <= trace_clock_pkg::count_none;
		end else if (speed == trace_clock_pkg::speed_class_fast &&
				mode_q == trace_clock_pkg::count_time) begin
			mode_q <= trace_clock_pkg::count_none;
		end else if (reg_write_in && reg_addr_in == `REG_COUNT_CTRL) begin
			if (reg_wdata_in[3:0] inside {4'h1, 4'h2, 4'h4, 4'h8} &&
					!(reg_wdata_in[3:0] == 4'h1 && speed != trace_clock_pkg::speed_class_slow))
				mode_q <= trace_clock_pkg::count_mode_t'(reg_wdata_in[3:0]);
			arm_gate_q <= reg_wdata_in[8] && DEEP_VARIANT != 0;
			expr_sel_q <= reg_wdata_in[16 +: PATTERNS];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			arm_src_q <= 1'b0;
			complex_q <= 1'b0;
		end else if (reg_write_in && reg_addr_in == `REG_ARM_CTRL) begin
			arm_src_q <= reg_wdata_in[`ARM_SOURCE_BIT];
		end else if (reg_write_in && reg_addr_in == `REG_SEQ_CTRL) begin
			complex_q <= reg_wdata_in[`SEQ_COMPLEX_BIT];
		end
	end

	// Patterns at 0x20 + 8*i (mask, value); secondaries at 0x40 + 4*t, reset to never
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < PATTERNS; i++)
				pattern_q[i] <= '0;
			for (int t = 0; t < TERMS; t++)
				secondary_q[t] <= '0;
		end else if (reg_write_in) begin
			for (int i = 0; i < PATTERNS; i++) begin
				if (reg_addr_in == 8'(`REG_PATTERN_BASE + 8 * i))
					pattern_q[i].addr_mask <= reg_wdata_in;
				if (reg_addr_in == 8'(`REG_PATTERN_BASE + 8 * i + 4))
					pattern_q[i].addr_value <= reg_wdata_in;
			end
			for (int t = 0; t < TERMS; t++)
				if (reg_addr_in == 8'(`REG_SECONDARY_BASE + 4 * t))
					secondary_q[t] <= reg_wdata_in[PATTERNS-1:0];
		end
	end

	always_comb begin
		rdata_d = 32'h0;
		if (reg_addr_in == `REG_CLOCK_CTRL)
			rdata_d = clock_ctrl_q;
		else if (reg_addr_in == `REG_COUNT_CTRL)
			rdata_d = {8'h0, 8'(expr_sel_q), 7'h0, arm_gate_q, 4'h0, mode_q};
		else if (reg_addr_in == `REG_ARM_CTRL)
			rdata_d = {31'h0, arm_src_q};
		else if (reg_addr_in == `REG_STATUS)
			rdata_d = {28'h0, DEEP_VARIANT != 0, trig_sel, counting, arm_q};
		else if (reg_addr_in == `REG_TAG_VALUE)
			rdata_d = 32'(tag_q);
		else if (reg_addr_in == `REG_SEQ_CTRL)
			rdata_d = {25'h0, seq_term_in, 3'h0, complex_q};
		for (int i = 0; i < PATTERNS; i++) begin
			if (reg_addr_in == 8'(`REG_PATTERN_BASE + 8 * i))
				rdata_d = pattern_q[i].addr_mask;
			if (reg_addr_in == 8'(`REG_PATTERN_BASE + 8 * i + 4))
				rdata_d = pattern_q[i].addr_value;
		end
		for (int t = 0; t < TERMS; t++)
			if (reg_addr_in == 8'(`REG_SECONDARY_BASE + 4 * t))
				rdata_d = 32'(secondary_q[t]);
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			reg_rdata_out <= 32'h0;
		else if (reg_read_in)
			reg_rdata_out <= rdata_d;
	end

	a_tag_clears: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		store |=> tag_q == '0)
		else $error("Tag not cleared after store");
	a_very_fast_none: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		speed == trace_clock_pkg::speed_class_very_fast |=> mode_q == trace_clock_pkg::count_none)
		else $error("Very fast class still counting");
	a_fast_no_time: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		speed == trace_clock_pkg::speed_class_fast |=> mode_q != trace_clock_pkg::count_time)
		else $error("Fast class in time mode");
	a_arm_sticky: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		arm_q && !(reg_write_in && reg_addr_in == `REG_ARM_CTRL) |=> arm_q)
		else $error("Arm dropped");
	a_arm_gating: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		arm_gate_q && !arm_q && !store |=> tag_q == $past(tag_q))
		else $error("Counted before arm");
	a_store_word: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		store |=> trace_word_out.valid && trace_word_out.tag == 16'($past(tag_q)))
		else $error("Stored tag wrong");
	a_depth_mode: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		!counting [*2] |-> trace_depth_out == 11'(`DEPTH_NO_COUNT))
		else $error("Depth wrong");
	a_primary_wins: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		primary_hit_in |-> !primary_clear_out)
		else $error("Cleared on primary");
	a_shallow_no_arm: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		DEEP_VARIANT == 0 |-> !arm_gate_q)
		else $error("Shallow arm gating");
	a_time_tick: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		mode_q == trace_clock_pkg::count_time && tb_tick && armed_ok && !store && tag_q != '1
		|=> tag_q == $past(tag_q) + 1'b1)
		else $error("Time tick not counted");
	a_depth_count: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		counting [*2] |-> trace_depth_out == 11'(`DEPTH_WITH_COUNT))
		else $error("Depth wrong while counting");

	c_store_seen:  cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) store);
	c_arm_latch:   cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) $rose(arm_q));
	c_secondary:   cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) primary_clear_out);
	c_both_branch: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		store && secondary_hit_out && primary_hit_in);
	c_time_tag:    cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		store && mode_q == trace_clock_pkg::count_time && tag_q != '0);

endmodule

// >>> shared/trace_clock_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts for the trace front end
// Assumes: 32-bit register port, word offsets
// Notes:   Included by the design and the bench
`ifndef TRACE_CLOCK_CFG_SVH
`define TRACE_CLOCK_CFG_SVH

`define REG_CLOCK_CTRL        8'h00
`define REG_COUNT_CTRL        8'h04
`define REG_ARM_CTRL          8'h08
`define REG_STATUS            8'h0c
`define REG_TAG_VALUE         8'h10
`define REG_SEQ_CTRL          8'h14
`define REG_PATTERN_BASE      8'h20
`define REG_SECONDARY_BASE    8'h40

`define CLK_EDGE_RISE_LSB     0
`define CLK_EDGE_FALL_LSB     5
`define CLK_QUAL_LOW_LSB      10
`define CLK_QUAL_HIGH_LSB     15
`define CLK_USER_BIT          20
`define CLK_BACKGROUND_BIT    21
`define CLK_SPEED_LSB         24

`define CLOCK_CTRL_RESET      32'h0110_0318
`define COUNT_MODE_LSB        0
`define COUNT_CTRL_RESET      32'h0000_0001
`define ARM_SOURCE_BIT        0
`define ARM_CLEAR_BIT         1
`define SEQ_COMPLEX_BIT       0
`define SEQ_TERM_LSB          4

`define TIMEBASE_NS           100
`define CLOCK_PERIOD_NS       50
`define TIMEBASE_CYCLES       ((`TIMEBASE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SLOW_LIMIT_MHZ        16
`define FAST_LIMIT_MHZ        20
`define DEPTH_NO_COUNT        1024
`define DEPTH_WITH_COUNT      512

`endif

// >>> shared/trace_clock_pkg.sv
// Purpose: Types shared by the trace front end
// Assumes: Constants come from trace_clock_cfg.svh
// Notes:   One-hot codes written out
package trace_clock_pkg;

	typedef enum logic [2:0] {
		speed_class_slow      = 3'h1,
		speed_class_fast      = 3'h2,
		speed_class_very_fast = 3'h4
	} speed_class_t;

	typedef enum logic [3:0] {
		count_time  = 4'h1,
		count_expr  = 4'h2,
		count_any   = 4'h4,
		count_none  = 4'h8
	} count_mode_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [7:0]  stat;
	} bus_state_t;

	typedef struct packed {
		logic        valid;
		bus_state_t  state;
		logic [15:0] tag;
		logic        tag_valid;
	} trace_word_t;

	typedef struct packed {
		logic [31:0] addr_mask;
		logic [31:0] addr_value;
	} pattern_t;

endpackage

// >>> tb/trace_bus_model.sv
// Purpose: Observed processor bus and trigger lines for the trace front end
// Assumes: Master clocks idle low outside bus cycles
// Notes:   A released bus shows inverted data so a stale value never matches
`timescale 1ns/10ps
module trace_bus_model (
	input  wire logic                   sys_clk_in,
	output logic [4:0]                  master_clk_out,
	output logic                        background_out,
	output trace_clock_pkg::bus_state_t bus_state_out,
	output logic                        trigger_line_one_out,
	output logic                        trigger_line_two_out
);
	initial begin
		master_clk_out = 5'h00;
		background_out = 1'b0;
		bus_state_out = '0;
		trigger_line_one_out = 1'b0;
		trigger_line_two_out = 1'b0;
	end
	// Setup, edge, four cycles high, four low, then release
	task automatic strobe(input int idx, input trace_clock_pkg::bus_state_t st);
		@(posedge sys_clk_in);
		bus_state_out <= st;
		@(posedge sys_clk_in);
		master_clk_out[idx] <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		master_clk_out[idx] <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		bus_state_out <= ~st;
	endtask
	task automatic level(input int idx, input logic v);
		@(posedge sys_clk_in);
		master_clk_out[idx] <= v;
	endtask
	task automatic trig(input int line, input logic v);
		@(posedge sys_clk_in);
		if (line == 1) begin
			trigger_line_one_out <= v;
		end else begin
			trigger_line_two_out <= v;
		end
	endtask
endmodule

// >>> tb/trace_clock_and_tag_counter_test.sv
// Purpose: Self-checking bench for the trace front end
// Assumes: Shallow variant, timebase of two cycles
// Notes:   Sequencer inputs driven by the bench around single stores
`timescale 1ns/10ps
`include "trace_clock_cfg.svh"
module trace_clock_and_tag_counter_test;
	logic                         sys_clk_in;
	logic                         sys_rst_in;
	logic [4:0]                   mclk;
	logic                         bg;
	trace_clock_pkg::bus_state_t  bstate;
	logic                         trig_one;
	logic                         trig_two;
	logic [7:0]                   reg_addr;
	logic [31:0]                  reg_wdata;
	logic                         reg_write;
	logic                         reg_read;
	logic [31:0]                  reg_rdata;
	trace_clock_pkg::trace_word_t word;
	trace_clock_pkg::trace_word_t last_word;
	trace_clock_pkg::bus_state_t  st;
	logic [10:0]                  depth;
	logic [31:0]                  rv;
	int                           bad_count;
	int                           checks_done;
	int                           stores;
	int                           seed;
	logic [2:0]                   term;
	logic                         prim_hit;
	logic                         prim_done;
	logic                         sec_hit;
	logic                         sec_prev;
	logic                         last_sec;
	logic                         prim_clr;
	int                           clears;

	trace_clock_and_tag_counter trace_clock_and_tag_counter_inst (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .master_clk_in(mclk),
		.background_in(bg), .bus_state_in(bstate), .trigger_line_one_in(trig_one),
		.trigger_line_two_in(trig_two), .seq_term_in(term), .primary_hit_in(prim_hit),
		.primary_done_in(prim_done), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_write_in(reg_write), .reg_read_in(reg_read), .reg_rdata_out(reg_rdata),
		.trace_word_out(word), .secondary_hit_out(sec_hit), .primary_clear_out(prim_clr),
		.trace_depth_out(depth));

	trace_bus_model trace_bus_model_inst (
		.sys_clk_in(sys_clk_in), .master_clk_out(mclk), .background_out(bg),
		.bus_state_out(bstate), .trigger_line_one_out(trig_one),
		.trigger_line_two_out(trig_two));

	always #25 sys_clk_in = ~sys_clk_in;

	always @(posedge sys_clk_in) begin
		if (word.valid === 1'b1) begin
			stores++;
			last_word = word;
			last_sec = sec_prev;
		end
		sec_prev = sec_hit;
		if (prim_clr === 1'b1) begin
			clears++;
		end
	end

	task automatic fail(input string m);
		bad_count++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			fail(m);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk_in);
		reg_write <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] mask,
			input logic [31:0] exp, input string m);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk_in);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata & mask, exp, m);
	endtask
	// Pin edge to stored word is three cycles, well inside one strobe
	task automatic store_chk(input int idx, input logic want);
		int n;
		n = stores;
		trace_bus_model_inst.strobe(idx, st);
		chk(32'(stores - n), {31'h0, want}, "store count");
	endtask
	// Secondary seen and occurrence clear counted at the store cycle only
	task automatic sec_chk(input logic [2:0] t, input logic ph, input logic pd,
			input logic exp_sec, input logic exp_clr, input string m);
		int n;
		n = clears;
		@(posedge sys_clk_in);
		term <= t;
		prim_hit <= ph;
		prim_done <= pd;
		store_chk(0, 1'b1);
		chk({31'h0, last_sec}, {31'h0, exp_sec}, m);
		chk(32'(clears - n), {31'h0, exp_clr}, m);
	endtask
	function automatic logic in_range(input logic [15:0] t, input int lo, input int hi);
		return (t >= lo) && (t <= hi);
	endfunction
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk_in);
		fail("run timed out");
		report_and_stop;
	end

	initial begin
		sys_clk_in = 1'b0;
		sys_rst_in = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		seed = 13;
		st = '0;
		term = 3'h0;
		prim_hit = 1'b0;
		prim_done = 1'b0;
		repeat (12) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		rdchk(`REG_CLOCK_CTRL, '1, `CLOCK_CTRL_RESET, "clock reset");
		rdchk(`REG_COUNT_CTRL, '1, `COUNT_CTRL_RESET, "count reset");
		chk({21'h0, depth}, 32'h200, "depth reset");
		rdchk(`REG_STATUS, 32'h1, 32'h0, "arm reset");
		rdchk(8'h1c, '1, 32'h0, "unmapped read");
		for (int i = 0; i < 4; i++) begin
			wr(`REG_COUNT_CTRL, 32'h1 << i);
			rdchk(`REG_COUNT_CTRL, '1, 32'h1 << i, "count mode");
			chk({21'h0, depth}, (i == 3) ? 32'h400 : 32'h200, "depth");
		end
		wr(`REG_COUNT_CTRL, 32'h3);
		rdchk(`REG_COUNT_CTRL, '1, 32'h8, "two-hot mode kept out");
		wr(`REG_COUNT_CTRL, 32'h101);
		rdchk(`REG_COUNT_CTRL, '1, 32'h1, "arm gate in shallow");
		wr(`REG_CLOCK_CTRL, 32'h0210_0001);
		rdchk(`REG_COUNT_CTRL, '1, 32'h8, "fast drops time");
		wr(`REG_COUNT_CTRL, 32'h2);
		rdchk(`REG_COUNT_CTRL, '1, 32'h2, "fast state count");
		wr(`REG_COUNT_CTRL, 32'h1);
		rdchk(`REG_COUNT_CTRL, '1, 32'h2, "fast time refused");
		wr(`REG_CLOCK_CTRL, 32'h0110_0001);
		wr(`REG_COUNT_CTRL, 32'h1);
		rdchk(`REG_COUNT_CTRL, '1, 32'h1, "slow time");
		wr(`REG_CLOCK_CTRL, 32'h0410_0001);
		rdchk(`REG_COUNT_CTRL, '1, 32'h8, "very fast none");
		wr(`REG_COUNT_CTRL, 32'h4);
		rdchk(`REG_COUNT_CTRL, '1, 32'h8, "very fast any refused");
		// Time tags: edge spacing 40 cycles then 10 cycles at two cycles a tick
		wr(`REG_CLOCK_CTRL, 32'h0110_0003);
		wr(`REG_COUNT_CTRL, 32'h1);
		store_chk(0, 1'b1);
		repeat (30) @(posedge sys_clk_in);
		store_chk(1, 1'b1);
		chk({31'h0, in_range(last_word.tag, 19, 21)}, 32'h1, "time tag");
		chk({31'h0, last_word.tag_valid}, 32'h1, "tag flagged");
		store_chk(0, 1'b1);
		chk({31'h0, in_range(last_word.tag, 4, 6)}, 32'h1, "tag cleared");
		for (int i = 0; i < 8; i++) begin
			st.addr = $random(seed);
			st.data = $random(seed);
			st.stat = 8'($random(seed));
			store_chk(i % 2, 1'b1);
			chk({31'h0, last_word.state === st}, 32'h1, "stored state");
		end
		// Qualifiers: rise J, low on N, high on M, user code off
		wr(`REG_CLOCK_CTRL, 32'h0104_4001);
		trace_bus_model_inst.level(4, 1'b1);
		store_chk(0, 1'b0);
		trace_bus_model_inst.level(4, 1'b0);
		store_chk(0, 1'b1);
		trace_bus_model_inst.level(4, 1'b1);
		trace_bus_model_inst.level(3, 1'b1);
		store_chk(0, 1'b1);
		// Secondary qualifiers: pattern 0 matches address bits 15:8 of 5a
		wr(`REG_PATTERN_BASE, 32'h0000_ff00);
		wr(`REG_PATTERN_BASE + 8'h04, 32'h0000_5a00);
		rdchk(`REG_PATTERN_BASE + 8'h04, '1, 32'h0000_5a00, "pattern value");
		wr(`REG_SECONDARY_BASE + 8'h08, 32'h1);
		wr(`REG_SEQ_CTRL, 32'h1);
		st.addr = $random(seed);
		st.addr[15:8] = 8'h5a;
		sec_chk(3'h2, 1'b0, 1'b0, 1'b1, 1'b1, "term secondary");
		sec_chk(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, "other term");
		sec_chk(3'h2, 1'b1, 1'b0, 1'b1, 1'b0, "primary wins");
		sec_chk(3'h2, 1'b0, 1'b1, 1'b1, 1'b0, "count done");
		st.addr[15:8] = 8'h5b;
		sec_chk(3'h2, 1'b0, 1'b0, 1'b0, 1'b0, "no pattern hit");
		st.addr[15:8] = 8'h5a;
		wr(`REG_SEQ_CTRL, 32'h0);
		sec_chk(3'h2, 1'b0, 1'b0, 1'b0, 1'b0, "restart unset");
		wr(`REG_SECONDARY_BASE, 32'h1);
		sec_chk(3'h5, 1'b0, 1'b0, 1'b1, 1'b1, "global restart");
		rdchk(`REG_SEQ_CTRL, '1, 32'h50, "term and arrangement");
		// Arm latch and source selection
		trace_bus_model_inst.trig(1, 1'b1);
		repeat (6) @(posedge sys_clk_in);
		rdchk(`REG_STATUS, 32'h1, 32'h1, "arm set");
		trace_bus_model_inst.trig(1, 1'b0);
		repeat (6) @(posedge sys_clk_in);
		rdchk(`REG_STATUS, 32'h1, 32'h1, "arm held");
		wr(`REG_ARM_CTRL, 32'h3);
		trace_bus_model_inst.trig(1, 1'b1);
		repeat (6) @(posedge sys_clk_in);
		rdchk(`REG_STATUS, 32'h1, 32'h0, "other line ignored");
		trace_bus_model_inst.trig(2, 1'b1);
		repeat (6) @(posedge sys_clk_in);
		rdchk(`REG_STATUS, 32'h1, 32'h1, "line two arms");
		report_and_stop;
	end
endmodule
